/* File: core/tgci_pkg.sv */
// Constants, types and state records of the terminal command interpreter
package tgci_pkg;
    // ========================================
    // Byte codes
    localparam logic [7:0] C_ESC = 8'h1b;
    localparam logic [7:0] C_LF = 8'h0a;
    localparam logic [7:0] C_DEL = 8'h7f;
    localparam logic [7:0] C_XON = 8'h11;
    localparam logic [7:0] C_XOFF = 8'h13;
    localparam logic [7:0] C_SP = 8'h20;
    localparam logic [7:0] E_GRAPH = 8'h31;
    localparam logic [7:0] E_LEAVE = 8'h32;
    localparam logic [7:0] E_ALT = 8'h46;
    localparam logic [7:0] E_TEXT = 8'h47;
    localparam logic [7:0] E_HOLD = 8'h5b;
    localparam logic [7:0] E_UNHOLD = 8'h5c;
    localparam logic [7:0] E_IDENT = 8'h5a;
    localparam logic [7:0] E_CPMARK = 8'h35;
    localparam logic [7:0] E_CPAUTO = 8'h36;
    localparam logic [7:0] E_CPOFF = 8'h37;
    // Identification reply, values arbitrary
    localparam logic [7:0] ID_B0 = 8'h23;
    localparam logic [7:0] ID_B1 = 8'h21;
    localparam logic [7:0] ID_B2 = 8'h30;
    // ========================================
    // Geometry
    localparam int GX_N = 512;
    localparam logic [7:0] GY_N = 8'hec;
    localparam logic [4:0] LAST_LINE = 5'h17;
    localparam logic [7:0] ALT_LO = 8'h60;
    localparam logic [4:0] NUM_SYM = 5'h1e;
    localparam logic [7:0] MARK_LEN = 8'h08;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 32;
    // ========================================
    // Graph opcodes, low nibble of a command byte
    localparam logic [3:0] OP_PT0 = 4'h0;
    localparam logic [3:0] OP_PT1 = 4'h1;
    localparam logic [3:0] OP_MKS = 4'h2;
    localparam logic [3:0] OP_MKC = 4'h3;
    localparam logic [3:0] OP_VLS = 4'h4;
    localparam logic [3:0] OP_VLC = 4'h5;
    localparam logic [3:0] OP_HLS = 4'h6;
    localparam logic [3:0] OP_HLC = 4'h7;
    localparam logic [3:0] OP_CTL = 4'h8;
    // ========================================
    // Types
    typedef enum logic [1:0] {
        MD_TEXT = 2'b00,
        MD_ALT = 2'b01,
        MD_GRAPH = 2'b10
    } tgci_mode_t;
    typedef struct packed {
        logic v;
        logic [7:0] code;
    } tgci_key_t;
    typedef struct packed {
        tgci_mode_t mode;
        logic ret_alt;
        logic esc;
        logic hold;
        logic autocp;
        logic [3:0] op;
        logic flag;
        logic [2:0] argn;
        logic [19:0] acc;
        logic [4:0] line;
        logic clr;
        logic [8:0] clr_i;
        logic [1:0] hist;
        logic blank;
        logic [1:0] idn;
        logic xoff;
        logic xon;
        tgci_key_t keyq;
        tgci_key_t held0;
        tgci_key_t held1;
        tgci_key_t pend;
        tgci_key_t tx;
        tgci_key_t chr;
        logic chr_alt;
        logic [4:0] sym;
        tgci_key_t ctl;
        logic scroll;
        logic cpmark;
        logic cpabove;
        logic cpline;
        logic cpscreen;
        logic pix;
    } tgci_st_t;
    typedef struct packed {
        logic [8:0] wp;
        logic [8:0] rp;
        logic rdy;
    } tgci_fst_t;
endpackage : tgci_pkg

/* File: core/tgci_top.sv */
// Byte FIFO and command interpreter of a graphics display terminal
`timescale 1ns/10ps

// ========================================
// Byte FIFO
module tgci_fifo import tgci_pkg::*; #(
    parameter int W = FIFO_W,
    parameter int D = FIFO_D
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    tgci_fst_t s_r, s_nxt;
    logic push, pop;
    logic [8:0] cnt;
    always_comb begin
        s_nxt = s_r;
        out_valid = (s_r.wp != s_r.rp);
        push = in_valid && s_r.rdy;
        pop = out_valid && out_ready;
        if (push) begin
            s_nxt.wp = s_r.wp + 9'h001;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 9'h001;
        end
        cnt = s_nxt.wp - s_nxt.rp;
        s_nxt.rdy = (cnt < 9'(D));
    end
    assign in_ready = s_r.rdy;
    assign out_data = mem[s_r.rp[AW-1:0]];
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{wp: 9'h000, rp: 9'h000, rdy: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
        if (push) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule : tgci_fifo

// ========================================
// Interpreter
module tgci_top import tgci_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic RX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    input wire logic KEY_DOWN,
    input wire logic KEY_UP,
    input wire logic [7:0] KEY_CODE,
    input wire logic SHIFT_KEY,
    input wire logic SCROLL_KEY,
    input wire logic COPY_KEY,
    output logic CHR_VALID,
    output logic [7:0] CHR_CODE,
    output logic CHR_ALT,
    output logic [4:0] CHR_SYM,
    output logic CTL_VALID,
    output logic [7:0] CTL_CODE,
    output logic SCROLL_UP,
    output logic HOLD,
    output logic GRAPH_MODE,
    output logic ALT_MODE,
    output logic COPY_MARK,
    output logic COPY_ABOVE,
    output logic COPY_LINE,
    output logic COPY_SCREEN,
    output logic AUTO_COPY,
    input wire logic [8:0] PIX_X,
    input wire logic [7:0] PIX_Y,
    input wire logic [6:0] PIX_COL,
    input wire logic [4:0] PIX_LINE,
    output logic GRAPH_PIX
);
    // ========================================
    // Helpers
    function automatic logic [2:0] arg_count(input logic [3:0] op);
        case (op)
            OP_PT0, OP_PT1: arg_count = 3'h4;
            OP_MKS, OP_MKC, OP_VLS, OP_VLC: arg_count = 3'h2;
            OP_HLS, OP_HLC: arg_count = 3'h2;
            OP_CTL: arg_count = 3'h1;
            default: arg_count = 3'h0;
        endcase
    endfunction : arg_count
    function automatic logic is_ctl(input logic [7:0] b);
        is_ctl = (b < C_SP) || (b == C_DEL);
    endfunction : is_ctl

    // ========================================
    // Graph memory, apart from text storage
    logic [7:0] gval [2][GX_N];
    logic gmark [2][GX_N];
    logic vline [GX_N];
    logic hline [GX_N];
    tgci_st_t s_r, s_nxt;
    logic [7:0] fb;
    logic fv, take, busy;
    logic pt_we, mk_we, vl_we, hl_we, gsel, wbit;
    logic [8:0] wx;
    logic [7:0] wy;
    logic [7:0] v0, v1;
    logic [1:0] onl, hst, mkr;

    tgci_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(CLK),
        .rst(RST),
        .in_data(RX_DATA),
        .in_valid(RX_VALID),
        .in_ready(RX_READY),
        .out_data(fb),
        .out_valid(fv),
        .out_ready(take)
    );

    // Stall input while clearing or while a reply or XOFF waits
    assign busy = s_r.clr || (s_r.idn != 2'h0) || s_r.xoff;
    assign take = fv && !busy;

    always_comb begin
        s_nxt = s_r;
        pt_we = 1'b0;
        mk_we = 1'b0;
        vl_we = 1'b0;
        hl_we = 1'b0;
        gsel = 1'b0;
        wbit = 1'b0;
        wx = 9'h000;
        wy = 8'h00;
        s_nxt.chr.v = 1'b0;
        s_nxt.ctl.v = 1'b0;
        s_nxt.scroll = 1'b0;
        s_nxt.cpmark = 1'b0;
        s_nxt.cpabove = 1'b0;
        s_nxt.cpline = 1'b0;
        s_nxt.cpscreen = 1'b0;
        // ========================================
        // Whole graph memory clear, one index per cycle
        if (s_r.clr) begin
            wx = s_r.clr_i;
            s_nxt.clr_i = s_r.clr_i + 9'h001;
            if (s_r.clr_i == 9'(GX_N - 1)) begin
                s_nxt.clr = 1'b0;
            end
        end
        // ========================================
        // Byte interpretation
        if (take) begin
            if (s_r.esc) begin
                s_nxt.esc = 1'b0;
                case (fb)
                    E_GRAPH: begin
                        if (s_r.mode != MD_GRAPH) begin
                            s_nxt.ret_alt = (s_r.mode == MD_ALT);
                            s_nxt.mode = MD_GRAPH;
                            s_nxt.argn = 3'h0;
                        end
                    end
                    E_LEAVE: begin
                        if (s_r.mode == MD_GRAPH) begin
                            s_nxt.mode = s_r.ret_alt ? MD_ALT : MD_TEXT;
                        end
                    end
                    E_ALT: begin
                        if (s_r.mode == MD_GRAPH) begin
                            s_nxt.ret_alt = 1'b1;
                        end else begin
                            s_nxt.mode = MD_ALT;
                        end
                    end
                    E_TEXT: begin
                        if (s_r.mode == MD_GRAPH) begin
                            s_nxt.ret_alt = 1'b0;
                        end else begin
                            s_nxt.mode = MD_TEXT;
                        end
                    end
                    E_HOLD: begin
                        s_nxt.hold = 1'b1;
                        s_nxt.xoff = 1'b1;
                    end
                    E_UNHOLD: s_nxt.hold = 1'b0;
                    E_IDENT: s_nxt.idn = 2'h3;
                    E_CPMARK: s_nxt.cpmark = 1'b1;
                    E_CPAUTO: begin
                        s_nxt.autocp = 1'b1;
                        s_nxt.cpabove = 1'b1;
                    end
                    E_CPOFF: s_nxt.autocp = 1'b0;
                    default: s_nxt.esc = 1'b0;
                endcase
            end else if (fb == C_ESC) begin
                s_nxt.esc = 1'b1;
            end else if (is_ctl(fb)) begin
                s_nxt.ctl = '{v: 1'b1, code: fb};
                if (fb == C_LF) begin
                    if (s_r.line == LAST_LINE) begin
                        s_nxt.scroll = 1'b1;
                    end else begin
                        s_nxt.line = s_r.line + 5'h01;
                    end
                    s_nxt.cpline = s_r.autocp;
                end
            end else if (s_r.mode == MD_GRAPH) begin
                if (fb[6]) begin
                    s_nxt.op = fb[3:0];
                    s_nxt.flag = fb[4];
                    s_nxt.argn = arg_count(fb[3:0]);
                end else if (s_r.argn != 3'h0) begin
                    s_nxt.acc = {s_r.acc[14:0], fb[4:0]};
                    s_nxt.argn = s_r.argn - 3'h1;
                    if (s_r.argn == 3'h1) begin
                        wx = {s_nxt.acc[8:5], s_nxt.acc[4:0]};
                        wy = {s_nxt.acc[7:5], s_nxt.acc[4:0]};
                        if (s_r.op == OP_PT0 || s_r.op == OP_PT1) begin
                            wx = {s_nxt.acc[18:15], s_nxt.acc[14:10]};
                        end
                        gsel = s_r.flag;
                        case (s_r.op)
                            OP_PT0, OP_PT1: begin
                                gsel = s_r.op[0];
                                pt_we = (wy < GY_N);
                            end
                            OP_MKS, OP_MKC: begin
                                mk_we = 1'b1;
                                wbit = (s_r.op == OP_MKS);
                            end
                            OP_VLS, OP_VLC: begin
                                vl_we = 1'b1;
                                wbit = (s_r.op == OP_VLS);
                            end
                            OP_HLS, OP_HLC: begin
                                hl_we = (wy < GY_N);
                                wbit = (s_r.op == OP_HLS);
                            end
                            OP_CTL: begin
                                s_nxt.hist = s_nxt.acc[1:0];
                                s_nxt.blank = s_nxt.acc[2];
                                s_nxt.clr = s_nxt.acc[3];
                                s_nxt.clr_i = 9'h000;
                            end
                            default: s_nxt.argn = 3'h0;
                        endcase
                    end
                end
            end else begin
                s_nxt.chr = '{v: 1'b1, code: fb};
                s_nxt.sym = 5'(fb - ALT_LO);
                s_nxt.chr_alt = (s_r.mode == MD_ALT) && (fb >= ALT_LO)
                    && (5'(fb - ALT_LO) < NUM_SYM);
            end
        end
        // ========================================
        // Local keys, serial traffic only for XON on shift+scroll in hold
        if (SCROLL_KEY && SHIFT_KEY && s_r.hold) begin
            s_nxt.xon = 1'b1;
        end
        if (COPY_KEY) begin
            s_nxt.cpscreen = !SHIFT_KEY;
            s_nxt.cpabove = s_nxt.cpabove || SHIFT_KEY;
            s_nxt.autocp = s_nxt.autocp || SHIFT_KEY;
        end
        // ========================================
        // Three-key rollover
        if (KEY_UP) begin
            if (s_r.held0.v && s_r.held0.code == KEY_CODE) begin
                s_nxt.held0 = s_r.pend;
                if (s_r.pend.v) begin
                    s_nxt.keyq = s_r.pend;
                end
                s_nxt.pend.v = 1'b0;
            end else if (s_r.held1.v && s_r.held1.code == KEY_CODE) begin
                s_nxt.held1 = s_r.pend;
                if (s_r.pend.v) begin
                    s_nxt.keyq = s_r.pend;
                end
                s_nxt.pend.v = 1'b0;
            end else if (s_r.pend.code == KEY_CODE) begin
                s_nxt.pend.v = 1'b0;
            end
        end else if (KEY_DOWN) begin
            if (!s_r.held0.v) begin
                s_nxt.held0 = '{v: 1'b1, code: KEY_CODE};
                s_nxt.keyq = '{v: 1'b1, code: KEY_CODE};
            end else if (!s_r.held1.v) begin
                s_nxt.held1 = '{v: 1'b1, code: KEY_CODE};
                s_nxt.keyq = '{v: 1'b1, code: KEY_CODE};
            end else begin
                s_nxt.pend = '{v: 1'b1, code: KEY_CODE};
            end
        end
        // ========================================
        // Transmitter: reply, XOFF, XON, key
        if (!s_r.tx.v || TX_READY) begin
            s_nxt.tx.v = 1'b1;
            if (s_r.idn != 2'h0) begin
                case (s_r.idn)
                    2'h3: s_nxt.tx.code = ID_B0;
                    2'h2: s_nxt.tx.code = ID_B1;
                    default: s_nxt.tx.code = ID_B2;
                endcase
                s_nxt.idn = s_r.idn - 2'h1;
            end else if (s_r.xoff) begin
                s_nxt.tx.code = C_XOFF;
                s_nxt.xoff = 1'b0;
            end else if (s_r.xon) begin
                s_nxt.tx.code = C_XON;
                s_nxt.xon = SCROLL_KEY && SHIFT_KEY && s_r.hold;
            end else if (s_r.keyq.v && !(KEY_UP || KEY_DOWN)) begin
                s_nxt.tx.code = s_r.keyq.code;
                s_nxt.keyq.v = 1'b0;
            end else begin
                s_nxt.tx.v = 1'b0;
            end
        end
        // ========================================
        // Graph pixel overlay
        onl = {(PIX_Y == v1), (PIX_Y == v0)};
        hst = {s_r.hist[1] && (PIX_Y < v1), s_r.hist[0] && (PIX_Y < v0)};
        mkr[0] = gmark[0][PIX_X] && (PIX_Y >= v0)
            && (PIX_Y < v0 + MARK_LEN);
        mkr[1] = gmark[1][PIX_X] && (PIX_Y >= v1)
            && (PIX_Y < v1 + MARK_LEN);
        s_nxt.pix = !s_r.blank && (PIX_COL != 7'h00) && (PIX_LINE != LAST_LINE)
            && (|onl || |hst || |mkr || vline[PIX_X]
            || hline[{1'b0, PIX_Y}]);
    end

    assign v0 = gval[0][PIX_X];
    assign v1 = gval[1][PIX_X];

    // ========================================
    // Graph memory writes
    always_ff @(posedge CLK) begin
        if (s_r.clr) begin
            gval[0][wx] <= 8'h00;
            gval[1][wx] <= 8'h00;
            gmark[0][wx] <= 1'b0;
            gmark[1][wx] <= 1'b0;
            vline[wx] <= 1'b0;
            hline[wx] <= 1'b0;
        end else begin
            if (pt_we) begin
                gval[gsel][wx] <= wy;
            end
            if (mk_we) begin
                gmark[gsel][wx] <= wbit;
            end
            if (vl_we) begin
                vline[wx] <= wbit;
            end
            if (hl_we) begin
                hline[{1'b0, wy}] <= wbit;
            end
        end
    end

    // ========================================
    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================
    // Outputs
    assign TX_DATA = s_r.tx.code;
    assign TX_VALID = s_r.tx.v;
    assign CHR_VALID = s_r.chr.v;
    assign CHR_CODE = s_r.chr.code;
    assign CHR_ALT = s_r.chr_alt;
    assign CHR_SYM = s_r.sym;
    assign CTL_VALID = s_r.ctl.v;
    assign CTL_CODE = s_r.ctl.code;
    assign SCROLL_UP = s_r.scroll;
    assign HOLD = s_r.hold;
    assign GRAPH_MODE = (s_r.mode == MD_GRAPH);
    assign ALT_MODE = (s_r.mode == MD_ALT);
    assign COPY_MARK = s_r.cpmark;
    assign COPY_ABOVE = s_r.cpabove;
    assign COPY_LINE = s_r.cpline;
    assign COPY_SCREEN = s_r.cpscreen;
    assign AUTO_COPY = s_r.autocp;
    assign GRAPH_PIX = s_r.pix;
endmodule : tgci_top

/* File: test/tgci_host.sv */
// Host computer model on the serial side
`timescale 1ns/10ps
module tgci_host import tgci_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] in_q[$];
    logic [7:0] got_q[$];
    logic paused = 1'b0;
    logic slow = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (rst) begin
            rx_valid <= 1'b0;
            paused <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                got_q.push_back(tx_data);
                if (tx_data == C_XOFF) paused <= 1'b1;
                if (tx_data == C_XON) paused <= 1'b0;
            end
            if (rx_valid && !rx_ready) begin
                rx_valid <= 1'b1;
            end else if (in_q.size() != 0 && !paused) begin
                rx_data <= in_q.pop_front();
                rx_valid <= 1'b1;
            end else begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
            end
        end
    end
endmodule : tgci_host

/* File: test/tgci_sva.sv */
// Port assertions of the terminal command interpreter
`timescale 1ns/10ps
module tgci_sva import tgci_pkg::*; (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic SHIFT_KEY,
    input wire logic SCROLL_KEY,
    input wire logic CHR_VALID,
    input wire logic [7:0] CHR_CODE,
    input wire logic CHR_ALT,
    input wire logic [4:0] CHR_SYM,
    input wire logic CTL_VALID,
    input wire logic [7:0] CTL_CODE,
    input wire logic HOLD,
    input wire logic GRAPH_MODE,
    input wire logic ALT_MODE,
    input wire logic [6:0] PIX_COL,
    input wire logic [4:0] PIX_LINE,
    input wire logic GRAPH_PIX
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ========================================
    // Checks
    tx_hold_a: assert property (TX_VALID && !TX_READY
        |=> TX_VALID && $stable(TX_DATA)) else $error("tx byte dropped");
    graph_nochr_a: assert property (GRAPH_MODE |-> !CHR_VALID)
        else $error("text char in graph mode");
    alt_sym_a: assert property (CHR_VALID && CHR_ALT |->
        CHR_CODE >= ALT_LO && CHR_SYM == 5'(CHR_CODE - ALT_LO))
        else $error("bad symbol index");
    text_noalt_a: assert property (CHR_VALID && !ALT_MODE |-> !CHR_ALT)
        else $error("symbol outside alternate mode");
    ctl_code_a: assert property (CTL_VALID |->
        CTL_CODE < C_SP && CTL_CODE != C_ESC) else $error("bad control");
    edge_pix_a: assert property (PIX_COL == 7'h00 ||
        PIX_LINE == LAST_LINE |=> !GRAPH_PIX) else $error("dot in label area");
    hold_xoff_a: assert property ($rose(HOLD) |->
        ##[0:40] TX_VALID && TX_DATA == C_XOFF) else $error("no xoff");
    xon_key_a: assert property (HOLD && SHIFT_KEY && SCROLL_KEY |->
        ##[1:40] TX_VALID && TX_DATA == C_XON) else $error("no xon");
endmodule : tgci_sva

bind tgci_top tgci_sva i_tgci_sva (.CLK(CLK), .RST(RST), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .SHIFT_KEY(SHIFT_KEY),
    .SCROLL_KEY(SCROLL_KEY), .CHR_VALID(CHR_VALID), .CHR_CODE(CHR_CODE),
    .CHR_ALT(CHR_ALT), .CHR_SYM(CHR_SYM), .CTL_VALID(CTL_VALID),
    .CTL_CODE(CTL_CODE), .HOLD(HOLD), .GRAPH_MODE(GRAPH_MODE),
    .ALT_MODE(ALT_MODE), .PIX_COL(PIX_COL), .PIX_LINE(PIX_LINE),
    .GRAPH_PIX(GRAPH_PIX));

/* File: test/tgci_top_tb.sv */
// Self-checking bench of the terminal command interpreter
`timescale 1ns/10ps
module tgci_top_tb import tgci_pkg::*;;
    logic CLK, RST = 1'b1, RX_VALID, RX_READY, TX_VALID, TX_READY;
    logic [7:0] RX_DATA, TX_DATA, CHR_CODE, CTL_CODE;
    logic SHIFT_KEY = 1'b0, SCROLL_KEY = 1'b0, CHR_VALID, CHR_ALT, CTL_VALID;
    logic HOLD, GRAPH_MODE, ALT_MODE, COPY_LINE, AUTO_COPY, GRAPH_PIX;
    logic KEY_DOWN = 1'b0, KEY_UP = 1'b0, COPY_KEY = 1'b0, SCROLL_UP;
    logic COPY_MARK, COPY_ABOVE, COPY_SCREEN;
    logic [7:0] KEY_CODE = 8'h00;
    logic [2:0] cp_seen = 3'h0;
    logic [4:0] CHR_SYM, PIX_LINE = 5'h00;
    logic [8:0] PIX_X = 9'h000;
    logic [7:0] PIX_Y = 8'h00, seen_chr = 8'h00, seen_ctl = 8'h00;
    logic [6:0] PIX_COL = 7'h01;
    logic [4:0] seen_sym = 5'h00;
    logic seen_alt = 1'b0;
    int fails = 0, total_checks = 0, chr_n = 0, line_n = 0, scroll_n = 0;
    tgci_top i_tgci_top (.*);
    tgci_host i_tgci_host (.clk(CLK), .rst(RST), .rx_data(RX_DATA),
        .rx_valid(RX_VALID), .rx_ready(RX_READY), .tx_data(TX_DATA),
        .tx_valid(TX_VALID), .tx_ready(TX_READY));
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (CHR_VALID) begin
            seen_chr <= CHR_CODE;
            seen_alt <= CHR_ALT;
            seen_sym <= CHR_SYM;
            chr_n <= chr_n + 1;
        end
        if (CTL_VALID) seen_ctl <= CTL_CODE;
        if (COPY_LINE) line_n <= line_n + 1;
        if (SCROLL_UP) scroll_n <= scroll_n + 1;
        cp_seen <= cp_seen | {COPY_SCREEN, COPY_ABOVE, COPY_MARK};
    end
    // ========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic send(input logic [7:0] b[$]);
        int n;
        n = 0;
        foreach (b[i]) i_tgci_host.in_q.push_back(b[i]);
        while ((i_tgci_host.in_q.size() != 0 || RX_VALID) && n < 2000) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 2000) fails++;
        repeat (8) @(posedge CLK);
        #1;
    endtask : send
    task automatic probe(input logic [7:0] y, input logic [6:0] c, input e);
        @(posedge CLK);
        PIX_X <= 9'h005;
        PIX_Y <= y;
        PIX_COL <= c;
        @(posedge CLK);
        #1;
        chk("graph_pix", 8'(e), 8'(GRAPH_PIX));
    endtask : probe
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    // ========================================
    // Scenarios
    task automatic t_modes;
        send('{8'h41, C_ESC, E_ALT, 8'h7e});
        chk("chr_sym", 8'h7e - ALT_LO, 8'(seen_sym));
        chk("alt_mode", 8'h01, 8'(ALT_MODE));
        send('{8'h5a, C_ESC, E_GRAPH, 8'h2a, 8'h07, C_ESC, 8'h7e, C_ESC, E_ALT});
        chk("chr_code", 8'h5a, seen_chr);
        chk("chr_alt", 8'h00, 8'(seen_alt));
        chk("graph", 8'h01, 8'(GRAPH_MODE));
        chk("ctl_code", 8'h07, seen_ctl);
        chk("chr_count", 8'h03, 8'(chr_n));
        send('{C_ESC, E_LEAVE});
        chk("alt_after", 8'h01, 8'(ALT_MODE));
        chk("graph", 8'h00, 8'(GRAPH_MODE));
    endtask : t_modes
    task automatic t_plot;
        send('{C_ESC, E_GRAPH, 8'h48, 8'h28});
        repeat (600) @(posedge CLK);
        send('{8'h40, 8'h20, 8'h25, 8'h20, 8'h2a});
        probe(8'h0a, 7'h01, 1'b1);
        probe(8'h0a, 7'h00, 1'b0);
        probe(8'h09, 7'h01, 1'b0);
        send('{8'h40, 8'h20, 8'h25, 8'h20, 8'h34, 8'h48, 8'h25});
        probe(8'h0a, 7'h01, 1'b0);
        send('{8'h48, 8'h20});
        probe(8'h0a, 7'h01, 1'b0);
        send('{8'h48, 8'h21, 8'h42, 8'h20, 8'h25, 8'h46, 8'h21, 8'h20,
            C_ESC, E_LEAVE, C_ESC, E_TEXT});
        probe(8'h0a, 7'h01, 1'b1);
        probe(8'h18, 7'h01, 1'b1);
        probe(8'h20, 7'h01, 1'b1);
        probe(8'h30, 7'h01, 1'b0);
    endtask : t_plot
    task automatic t_serial;
        i_tgci_host.slow = 1'b1;
        send('{C_ESC, E_IDENT});
        repeat (10) @(posedge CLK);
        i_tgci_host.slow = 1'b0;
        chk("id_2", ID_B2, i_tgci_host.got_q.pop_back());
        chk("id_1", ID_B1, i_tgci_host.got_q.pop_back());
        chk("id_0", ID_B0, i_tgci_host.got_q.pop_back());
        send('{C_ESC, E_HOLD});
        chk("xoff", C_XOFF, i_tgci_host.got_q.pop_back());
        SHIFT_KEY <= 1'b1;
        SCROLL_KEY <= 1'b1;
        @(posedge CLK);
        SCROLL_KEY <= 1'b0;
        SHIFT_KEY <= 1'b0;
        repeat (10) @(posedge CLK);
        chk("xon", C_XON, i_tgci_host.got_q.pop_back());
        send('{C_ESC, E_UNHOLD, C_ESC, E_CPAUTO, C_LF});
        chk("hold", 8'h00, 8'(HOLD));
        chk("auto", 8'h01, 8'(AUTO_COPY));
        SCROLL_KEY <= 1'b1;
        @(posedge CLK);
        SCROLL_KEY <= 1'b0;
        send('{C_ESC, E_CPOFF, C_LF, C_ESC, E_CPMARK});
        chk("tx_count", 8'h00, 8'(i_tgci_host.got_q.size()));
        chk("copy_lines", 8'h01, 8'(line_n));
    endtask : t_serial
    task automatic key(input logic dn, input logic [7:0] c);
        @(posedge CLK);
        KEY_DOWN <= dn;
        KEY_UP <= !dn;
        KEY_CODE <= c;
        @(posedge CLK);
        KEY_DOWN <= 1'b0;
        KEY_UP <= 1'b0;
        repeat (6) @(posedge CLK);
    endtask : key
    task automatic t_keys;
        key(1'b1, 8'h61);
        key(1'b1, 8'h62);
        key(1'b1, 8'h63);
        chk("keys_held", 8'h02, 8'(i_tgci_host.got_q.size()));
        key(1'b0, 8'h61);
        key(1'b0, 8'h63);
        key(1'b0, 8'h62);
        chk("key_1", 8'h61, i_tgci_host.got_q.pop_front());
        chk("key_2", 8'h62, i_tgci_host.got_q.pop_front());
        chk("key_3", 8'h63, i_tgci_host.got_q.pop_front());
        COPY_KEY <= 1'b1;
        @(posedge CLK);
        COPY_KEY <= 1'b0;
        repeat (4) @(posedge CLK);
        chk("key_tx", 8'h00, 8'(i_tgci_host.got_q.size()));
        chk("copies", 8'h07, 8'(cp_seen));
    endtask : t_keys
    task automatic t_scroll;
        logic [7:0] q[$];
        repeat (24) q.push_back(C_LF);
        send(q);
        chk("scrolls", 8'h03, 8'(scroll_n));
    endtask : t_scroll
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        t_modes();
        t_plot();
        t_serial();
        t_keys();
        t_scroll();
        stop_test();
    end
endmodule : tgci_top_tb
